// file: design/charge_timer_control_regs.sv
// Purpose: Timer configuration and charger control registers with decoded outputs
// Assumes: Byte register port from the serial interface on ref_clk; status inputs synchronised here
// Notes:   Register reset command and watchdog expiry arrive as one-cycle pulses from ref_clk logic
// Operation
// - The top-off field decodes 0 off, 1 to 15, 2 to 30 and 3 to 45 minutes, default off.
// - Timer bit 5 enables the one-hour trickle timer, default on.
// - Timer bit 4 enables the pre-charge timer, default on.
// - Timer bit 3 enables the fast-charge timer, default on.
// - Fast duration decodes 0 to 5, 1 to 8, 2 to 12 and 3 to 24 hours, default code 2.
// - Timer bit 0 halves timer speed during power limiting or thermal regulation, default on.
// - Control bit 7 applies battery discharge during overvoltage faults, default on.
// - Control bit 6 forces battery discharge regardless of overvoltage, default off.
// - Control bit 5 allows charging, default on and restored on watchdog expiry.
// - Control bit 4 enables the input current optimizer, default off.
// - Control bit 3 can only be set, starts the optimizer while enabled and clears once it starts.
// - Control bit 2 selects high impedance and clears itself when an adapter is plugged in.
// - Control bit 1 enables charge termination, default on.
// - The register reset command restores all defaults and resets the timer.
`timescale 1ns/1ps
module charge_timer_control_regs
    import charge_timer_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_reset_cmd,
    input  wire logic       watchdog_expire,
    input  wire logic       optimizer_started,
    input  wire logic       adapter_present,
    input  wire logic       bat_ovp_fault,
    input  wire logic       regulation_active,
    output logic      [7:0] reg_rdata,
    output logic            reg_rvalid,
    output timer_cfg_s      timer_cfg,
    output charger_ctl_s    charger_ctl,
    output logic            discharge_on,
    output logic            timer_slow,
    output logic            timer_restart
);
    logic [7:0] tmr_val;
    logic [7:0] ctl_val;
    logic       wr_tmr;
    logic       wr_ctl;
    logic [7:0] ctl_clear;
    logic [7:0] ctl_wdata;

    // Two-flop synchronisers for pin-level status
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic       adapter_prev_q;
    logic       adapter_plug;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync1_q        <= 3'h0;
            sync2_q        <= 3'h0;
            adapter_prev_q <= 1'b0;
        end else begin
            sync1_q        <= {bat_ovp_fault, regulation_active, adapter_present};
            sync2_q        <= sync1_q;
            adapter_prev_q <= sync2_q[0];
        end
    end

    // Rising edge of adapter presence
    assign adapter_plug = sync2_q[0] & ~adapter_prev_q;

    // Address decode
    assign wr_tmr = reg_wr && (reg_addr == OFF_TIMER_CFG);
    assign wr_ctl = reg_wr && (reg_addr == OFF_CHG_CTRL0);

    // Hardware clears and kick write filtering
    always_comb begin
        ctl_clear = 8'h00;
        ctl_wdata = reg_wdata;
        // Kick set-only, self-clear, watchdog restore not undone by a write
        ctl_wdata[OPT_KICK_BIT] = reg_wdata[OPT_KICK_BIT] | (ctl_val[OPT_KICK_BIT] & ~watchdog_expire);
        ctl_clear[OPT_KICK_BIT] = optimizer_started;
        ctl_clear[HIZ_BIT] = adapter_plug;
    end

    reg_byte_cell #(
        .RESET_VAL (RST_TIMER_CFG),
        .WD_MASK   (8'hff),
        .WR_MASK   (8'hff)
    ) u_timer_reg (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .wr_en     (wr_tmr),
        .wr_data   (reg_wdata),
        .cmd_reset (reg_reset_cmd),
        .wd_expire (watchdog_expire),
        .hw_clear  (8'h00),
        .value     (tmr_val)
    );

    // Control register with partial watchdog restore
    reg_byte_cell #(
        .RESET_VAL (RST_CHG_CTRL0),
        .WD_MASK   (WD_MASK_CTRL0),
        .WR_MASK   (WR_MASK_CTRL0)
    ) u_ctrl_reg (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .wr_en     (wr_ctl),
        .wr_data   (ctl_wdata),
        .cmd_reset (reg_reset_cmd),
        .wd_expire (watchdog_expire),
        .hw_clear  (ctl_clear),
        .value     (ctl_val)
    );

    timer_cfg_s   tcfg_d;
    charger_ctl_s cctl_d;
    logic [7:0]   rdata_d;

    // Field decode
    always_comb begin
        unique case (tmr_val[TOPOFF_HI:TOPOFF_LO])
            2'h0: tcfg_d.topoff_minutes = 12'h000;
            2'h1: tcfg_d.topoff_minutes = TOPOFF_MIN_1;
            2'h2: tcfg_d.topoff_minutes = TOPOFF_MIN_2;
            2'h3: tcfg_d.topoff_minutes = TOPOFF_MIN_3;
        endcase
        tcfg_d.topoff_active      = |tmr_val[TOPOFF_HI:TOPOFF_LO];
        tcfg_d.trickle_timer_on   = tmr_val[TRICKLE_BIT];
        tcfg_d.precharge_timer_on = tmr_val[PRECHG_BIT];
        tcfg_d.fast_timer_on      = tmr_val[FAST_BIT];
        unique case (tmr_val[FAST_DUR_HI:FAST_DUR_LO])
            2'h0: tcfg_d.fast_minutes = FAST_MIN_0;
            2'h1: tcfg_d.fast_minutes = FAST_MIN_1;
            2'h2: tcfg_d.fast_minutes = FAST_MIN_2;
            2'h3: tcfg_d.fast_minutes = FAST_MIN_3;
        endcase
        tcfg_d.timer_half_speed = tmr_val[HALF_SPEED_BIT];
        cctl_d.auto_bat_discharge    = ctl_val[AUTO_DIS_BIT];
        cctl_d.forced_bat_discharge  = ctl_val[FORCE_DIS_BIT];
        cctl_d.charging_allowed      = ctl_val[CHG_EN_BIT];
        cctl_d.input_optimizer_on    = ctl_val[OPT_EN_BIT];
        cctl_d.input_optimizer_start = ctl_val[OPT_KICK_BIT] & ctl_val[OPT_EN_BIT];
        cctl_d.high_impedance_on     = ctl_val[HIZ_BIT];
        cctl_d.termination_on        = ctl_val[TERM_BIT];
        // Read mux, unmapped reads zero
        rdata_d = 8'h00;
        if (reg_addr == OFF_TIMER_CFG) begin
            rdata_d = tmr_val;
        end else if (reg_addr == OFF_CHG_CTRL0) begin
            rdata_d = ctl_val & WR_MASK_CTRL0;
        end
    end

    // Output registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            timer_cfg     <= '0;
            charger_ctl   <= '0;
            reg_rdata     <= 8'h00;
            reg_rvalid    <= 1'b0;
            discharge_on  <= 1'b0;
            timer_slow    <= 1'b0;
            timer_restart <= 1'b0;
        end else begin
            timer_cfg     <= tcfg_d;
            charger_ctl   <= cctl_d;
            reg_rvalid    <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_d;
            end
            discharge_on  <= ctl_val[FORCE_DIS_BIT] | (ctl_val[AUTO_DIS_BIT] & sync2_q[2]);
            timer_slow    <= tmr_val[HALF_SPEED_BIT] & sync2_q[1];
            timer_restart <= reg_reset_cmd;
        end
    end

    a_auto_discharge: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (ctl_val[AUTO_DIS_BIT] && sync2_q[2]) |=> discharge_on)
        else $error("auto discharge missing during fault");

    a_forced_discharge: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ctl_val[FORCE_DIS_BIT] |=> discharge_on)
        else $error("forced discharge missing");

    a_cmd_reset_defaults: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_reset_cmd |=> (tmr_val == RST_TIMER_CFG && ctl_val == RST_CHG_CTRL0 && timer_restart))
        else $error("register reset did not restore defaults");

    // Watchdog keeps discharge, optimizer enable and high impedance bits
    a_wd_keeps_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (watchdog_expire && !reg_reset_cmd && !wr_ctl && !adapter_plug)
        |=> ((ctl_val & 8'hd4) == ($past(ctl_val) & 8'hd4)) && ctl_val[CHG_EN_BIT] && ctl_val[TERM_BIT])
        else $error("watchdog restore touched wrong bits");

    a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !ctl_val[RSVD_BIT] && !(reg_rvalid && ($past(reg_addr) == OFF_CHG_CTRL0) && reg_rdata[RSVD_BIT]))
        else $error("reserved bit set");

    a_kick_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (optimizer_started && !reg_reset_cmd) |=> !ctl_val[OPT_KICK_BIT])
        else $error("kick bit not cleared after start");

    a_hiz_plug_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (adapter_plug && !reg_reset_cmd) |=> !ctl_val[HIZ_BIT])
        else $error("high impedance not cleared on plug");

    a_half_speed: assert property (@(posedge ref_clk) disable iff (!rst_n)
        timer_slow |-> $past(tmr_val[HALF_SPEED_BIT]) && $past(sync2_q[1]))
        else $error("timer slowed without cause");

    // Default fast duration after reset command
    a_fast_default: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reg_reset_cmd |=> ##1 (timer_cfg.fast_minutes == FAST_MIN_2) && !timer_cfg.topoff_active)
        else $error("fast duration default wrong");

    // Watchdog restores the whole timer register
    a_timer_wd_restore: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (watchdog_expire && !reg_reset_cmd && !wr_tmr) |=> (tmr_val == RST_TIMER_CFG))
        else $error("timer register not restored by watchdog");

    a_timer_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_tmr && !reg_reset_cmd) |=> (tmr_val == $past(reg_wdata)))
        else $error("timer write lost");

    a_topoff_longest: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (tmr_val[TOPOFF_HI:TOPOFF_LO] == 2'h3)
        |=> (timer_cfg.topoff_minutes == TOPOFF_MIN_3) && timer_cfg.topoff_active)
        else $error("top-off duration decode wrong");

    a_fast_longest: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (tmr_val[FAST_DUR_HI:FAST_DUR_LO] == 2'h3) |=> (timer_cfg.fast_minutes == FAST_MIN_3))
        else $error("fast duration decode wrong");

    // Timer enables follow the written byte
    a_timer_enables: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_tmr && !reg_reset_cmd) |=> ##1
        ({timer_cfg.trickle_timer_on, timer_cfg.precharge_timer_on, timer_cfg.fast_timer_on,
          timer_cfg.timer_half_speed} ==
         {$past(reg_wdata[TRICKLE_BIT:FAST_BIT], 2), $past(reg_wdata[HALF_SPEED_BIT], 2)}))
        else $error("timer enables differ from written byte");

    // Control write lands apart from kick and reserved bits
    a_ctl_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_ctl && !reg_reset_cmd && !adapter_plug) |=> ((ctl_val & 8'hf6) == ($past(reg_wdata) & 8'hf6)))
        else $error("control write lost");

    // Writing zero leaves the kick bit set
    a_kick_set_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_ctl && ctl_val[OPT_KICK_BIT] && !reg_reset_cmd && !watchdog_expire && !optimizer_started)
        |=> ctl_val[OPT_KICK_BIT])
        else $error("kick bit cleared by software");

    // Start request gated by the optimizer enable
    a_kick_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (ctl_val[OPT_KICK_BIT] && !ctl_val[OPT_EN_BIT]) |=> !charger_ctl.input_optimizer_start)
        else $error("optimizer started while disabled");

    // Timer restart only after the command
    a_restart_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
        timer_restart |-> $past(reg_reset_cmd))
        else $error("timer restart without command");

    a_charge_blocked: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !ctl_val[CHG_EN_BIT] |=> !charger_ctl.charging_allowed)
        else $error("charging allowed while disabled");

    a_term_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !ctl_val[TERM_BIT] |=> !charger_ctl.termination_on)
        else $error("termination on while disabled");

    // High impedance output follows its bit
    a_hiz_output: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ctl_val[HIZ_BIT] |=> charger_ctl.high_impedance_on)
        else $error("high impedance output missing");

    a_discharge_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!ctl_val[FORCE_DIS_BIT] && !(ctl_val[AUTO_DIS_BIT] && sync2_q[2])) |=> !discharge_on)
        else $error("discharge without cause");

    a_slow_regulation: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (tmr_val[HALF_SPEED_BIT] && sync2_q[1]) |=> timer_slow)
        else $error("timer not slowed under regulation");

endmodule : charge_timer_control_regs

// file: design/charge_timer_pkg.sv
// Purpose: Shared constants and carriers for the charge timer and charger control registers
// Assumes: 8-bit registers behind a byte-wide register port on the host serial bus
// Notes:   Offsets, field positions, reset values and durations are named once here
package charge_timer_pkg;

    // Register offsets
    localparam logic [7:0] OFF_TIMER_CFG  = 8'h0e;
    localparam logic [7:0] OFF_CHG_CTRL0  = 8'h0f;

    // Reset values
    localparam logic [7:0] RST_TIMER_CFG  = 8'h3d;
    localparam logic [7:0] RST_CHG_CTRL0  = 8'ha2;

    // Timer register field positions
    localparam int TOPOFF_HI      = 7;
    localparam int TOPOFF_LO      = 6;
    localparam int TRICKLE_BIT    = 5;
    localparam int PRECHG_BIT     = 4;
    localparam int FAST_BIT       = 3;
    localparam int FAST_DUR_HI    = 2;
    localparam int FAST_DUR_LO    = 1;
    localparam int HALF_SPEED_BIT = 0;

    // Charger control field positions
    localparam int AUTO_DIS_BIT   = 7;
    localparam int FORCE_DIS_BIT  = 6;
    localparam int CHG_EN_BIT     = 5;
    localparam int OPT_EN_BIT     = 4;
    localparam int OPT_KICK_BIT   = 3;
    localparam int HIZ_BIT        = 2;
    localparam int TERM_BIT       = 1;
    localparam int RSVD_BIT       = 0;

    // Bits of the control register restored on watchdog expiry
    localparam logic [7:0] WD_MASK_CTRL0  = 8'h2a;
    // Bits of the control register that software may write
    localparam logic [7:0] WR_MASK_CTRL0  = 8'hfe;

    // Durations in minutes
    localparam logic [11:0] TOPOFF_MIN_1  = 12'h00f;
    localparam logic [11:0] TOPOFF_MIN_2  = 12'h01e;
    localparam logic [11:0] TOPOFF_MIN_3  = 12'h02d;
    localparam logic [11:0] TRICKLE_MIN   = 12'h03c;
    localparam logic [11:0] FAST_MIN_0    = 12'h12c;
    localparam logic [11:0] FAST_MIN_1    = 12'h1e0;
    localparam logic [11:0] FAST_MIN_2    = 12'h2d0;
    localparam logic [11:0] FAST_MIN_3    = 12'h5a0;

    // Decoded configuration toward the charger core
    typedef struct packed {
        logic [11:0] topoff_minutes;
        logic        topoff_active;
        logic        trickle_timer_on;
        logic        precharge_timer_on;
        logic        fast_timer_on;
        logic [11:0] fast_minutes;
        logic        timer_half_speed;
    } timer_cfg_s;

    typedef struct packed {
        logic auto_bat_discharge;
        logic forced_bat_discharge;
        logic charging_allowed;
        logic input_optimizer_on;
        logic input_optimizer_start;
        logic high_impedance_on;
        logic termination_on;
    } charger_ctl_s;

endpackage : charge_timer_pkg

// file: design/reg_byte_cell.sv
// Purpose: One 8-bit control register with masked write, two restore sources and hardware clears
// Assumes: Single clock, synchronous active-low reset
// Notes:   Hardware clears win over a same-cycle software write of the same bit
`timescale 1ns/1ps
module reg_byte_cell #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WD_MASK   = 8'hff,
    parameter logic [7:0] WR_MASK   = 8'hff
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    input  wire logic       cmd_reset,
    input  wire logic       wd_expire,
    input  wire logic [7:0] hw_clear,
    output logic      [7:0] value
);
    logic [7:0] val_q;
    logic [7:0] val_d;

    // Next value: reset command alone, else watchdog restore, then write, then hardware clears
    always_comb begin
        val_d = val_q;
        if (cmd_reset) begin
            val_d = RESET_VAL;
        end else begin
            if (wd_expire) begin
                val_d = (val_q & ~WD_MASK) | (RESET_VAL & WD_MASK);
            end
            if (wr_en) begin
                val_d = (val_d & ~WR_MASK) | (wr_data & WR_MASK);
            end
            val_d = val_d & ~hw_clear;
        end
    end

    // Register stage
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            val_q <= RESET_VAL;
        end else begin
            val_q <= val_d;
        end
    end

    assign value = val_q;
endmodule : reg_byte_cell

// file: sim/host_model.sv
// Purpose: Host side of the byte register port
// Assumes: Requests launched by the rising edge of ref_clk
// Notes:   Released address and data show their inverse
`timescale 1ns/1ps
module host_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata
);
    // Idle bus at time zero
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    // Bytes sent unchanged
    // One write strobe, held up to the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask : wr

    // One read strobe, answer taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        @(negedge ref_clk);
        d = reg_rdata;
        v = reg_rvalid;
    endtask : rd
endmodule : host_model

// file: sim/charge_timer_control_regs_tb.sv
// Purpose: Self-checking bench for the timer and charger control registers
// Assumes: 20 MHz ref_clk, synchronous active-low reset
// Notes:   Status inputs pass two sync flops, so waits allow four cycles
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module charge_timer_control_regs_tb import charge_timer_pkg::*;;
    logic         ref_clk, rst_n, reg_wr, reg_rd, reg_rvalid, rv;
    logic         reg_reset_cmd, watchdog_expire, optimizer_started;
    logic         adapter_present, bat_ovp_fault, regulation_active;
    logic         discharge_on, timer_slow, timer_restart;
    logic   [7:0] reg_addr, reg_wdata, reg_rdata, rdat;
    timer_cfg_s   timer_cfg;
    charger_ctl_s charger_ctl;
    int           failures;
    int           compares;
    logic  [11:0] topoff_tab [4];
    logic  [11:0] fast_tab   [4];

    charge_timer_control_regs i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_reset_cmd(reg_reset_cmd),
        .watchdog_expire(watchdog_expire), .optimizer_started(optimizer_started),
        .adapter_present(adapter_present), .bat_ovp_fault(bat_ovp_fault),
        .regulation_active(regulation_active), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .timer_cfg(timer_cfg), .charger_ctl(charger_ctl), .discharge_on(discharge_on),
        .timer_slow(timer_slow), .timer_restart(timer_restart));
    host_model i_host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    // Free-running 50 ns clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Expected decode of a timer byte
    function automatic timer_cfg_s exp_timer(input logic [7:0] v);
        timer_cfg_s t;
        t.topoff_minutes     = topoff_tab[v[7:6]];
        t.topoff_active      = |v[7:6];
        t.trickle_timer_on   = v[5];
        t.precharge_timer_on = v[4];
        t.fast_timer_on      = v[3];
        t.fast_minutes       = fast_tab[v[2:1]];
        t.timer_half_speed   = v[0];
        return t;
    endfunction : exp_timer

    // Expected decode of a control byte
    function automatic charger_ctl_s exp_ctl(input logic [7:0] v);
        return '{v[7], v[6], v[5], v[4], v[3] & v[4], v[2], v[1]};
    endfunction : exp_ctl

    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : wait_clk

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        i_host.rd(a, rdat, rv);
        `CHK(rv, 1'b1)
        `CHK(rdat, e)
    endtask : chk_rd

    task automatic t_defaults();
        chk_rd(OFF_TIMER_CFG, RST_TIMER_CFG); // timer default
        chk_rd(OFF_CHG_CTRL0, RST_CHG_CTRL0); // control default
        chk_rd(8'h10, 8'h00);
        `CHK(timer_cfg, exp_timer(RST_TIMER_CFG)) // defaults
        `CHK(charger_ctl, exp_ctl(RST_CHG_CTRL0)) // defaults
    endtask : t_defaults

    task automatic t_timer();
        logic [7:0] v;
        @(posedge ref_clk);
        regulation_active <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            v = {k[1:0], k[0], ~k[0], k[1], k[1:0], ~k[1]};
            i_host.wr(OFF_TIMER_CFG, v);
            chk_rd(OFF_TIMER_CFG, v); // readback
            `CHK(timer_cfg, exp_timer(v)) // decode
            `CHK(timer_slow, v[0]) // half speed
        end
        @(posedge ref_clk);
        regulation_active <= 1'b0;
        wait_clk(4);
        `CHK(timer_slow, 1'b0) // normal speed
    endtask : t_timer

    task automatic t_ctrl();
        i_host.wr(OFF_CHG_CTRL0, 8'hff);
        chk_rd(OFF_CHG_CTRL0, 8'hfe); // reserved reads zero
        `CHK(charger_ctl, exp_ctl(8'hfe)) // all set
        i_host.wr(OFF_CHG_CTRL0, 8'h00);
        chk_rd(OFF_CHG_CTRL0, 8'h08); // set only
        `CHK(charger_ctl.input_optimizer_start, 1'b0) // gated while off
        @(posedge ref_clk);
        optimizer_started <= 1'b1;
        @(posedge ref_clk);
        optimizer_started <= 1'b0;
        chk_rd(OFF_CHG_CTRL0, 8'h00); // cleared on start
    endtask : t_ctrl

    task automatic t_discharge();
        i_host.wr(OFF_CHG_CTRL0, 8'h80);
        wait_clk(4);
        `CHK(discharge_on, 1'b0) // no fault
        @(posedge ref_clk);
        bat_ovp_fault <= 1'b1;
        wait_clk(4);
        `CHK(discharge_on, 1'b1) // fault discharges
        i_host.wr(OFF_CHG_CTRL0, 8'h00);
        bat_ovp_fault <= 1'b0;
        wait_clk(4);
        `CHK(discharge_on, 1'b0) // both off
        i_host.wr(OFF_CHG_CTRL0, 8'h40);
        wait_clk(2);
        `CHK(discharge_on, 1'b1) // forced without fault
    endtask : t_discharge

    task automatic t_hiz();
        i_host.wr(OFF_CHG_CTRL0, 8'h04);
        chk_rd(OFF_CHG_CTRL0, 8'h04); // set by host
        `CHK(charger_ctl.high_impedance_on, 1'b1) // mode on
        @(posedge ref_clk);
        adapter_present <= 1'b1;
        wait_clk(4);
        chk_rd(OFF_CHG_CTRL0, 8'h00); // plug clears
    endtask : t_hiz

    task automatic t_restore();
        i_host.wr(OFF_TIMER_CFG, 8'hc0);
        i_host.wr(OFF_CHG_CTRL0, 8'hdc);
        @(posedge ref_clk);
        watchdog_expire <= 1'b1;
        @(posedge ref_clk);
        watchdog_expire <= 1'b0;
        chk_rd(OFF_TIMER_CFG, RST_TIMER_CFG); // timer restored
        chk_rd(OFF_CHG_CTRL0, 8'hf6); // partial restore
        @(posedge ref_clk);
        reg_reset_cmd <= 1'b1;
        @(posedge ref_clk);
        reg_reset_cmd <= 1'b0;
        @(negedge ref_clk);
        `CHK(timer_restart, 1'b1) // timer restart
        chk_rd(OFF_CHG_CTRL0, RST_CHG_CTRL0); // defaults back
        `CHK(charger_ctl, exp_ctl(RST_CHG_CTRL0)) // decoded defaults
    endtask : t_restore

    task automatic end_of_test();
        if (failures == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    // Main sequence
    initial begin
        failures          = 0;
        compares          = 0;
        topoff_tab        = '{12'h000, TOPOFF_MIN_1, TOPOFF_MIN_2, TOPOFF_MIN_3};
        fast_tab          = '{FAST_MIN_0, FAST_MIN_1, FAST_MIN_2, FAST_MIN_3};
        rst_n             = 1'b0;
        reg_reset_cmd     = 1'b0;
        watchdog_expire   = 1'b0;
        optimizer_started = 1'b0;
        adapter_present   = 1'b0;
        bat_ovp_fault     = 1'b0;
        regulation_active = 1'b0;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_defaults();
        t_timer();
        t_ctrl();
        t_discharge();
        t_hiz();
        t_restore();
        end_of_test();
    end

    // Hang guard, far beyond the roughly one hundred cycles needed
    initial begin
        repeat (5000) @(posedge ref_clk);
        failures++;
        end_of_test();
    end
endmodule : charge_timer_control_regs_tb
